/* hw/dhrs_nvm_loader.sv */
// sequential reload of settings from non-volatile storage
`timescale 1ns/1ps
module dhrs_nvm_loader #(
    parameter int WORDS = 4,
    parameter int DW    = 8
) (
    input  wire logic          sys_clk_in,    // system clock
    input  wire logic          sys_rst_in,    // sync reset, high
    input  wire logic          start_in,      // one-cycle start pulse
    input  wire logic [DW-1:0] nvm_data_in,   // storage read data
    output logic [$clog2(WORDS)-1:0] nvm_addr_out, // storage word index
    output logic [DW-1:0]      word_data_out, // captured word
    output logic [$clog2(WORDS)-1:0] word_idx_out, // captured index
    output logic               word_we_out,   // capture strobe
    output logic               busy_out       // load in progress
);
    localparam int AW = $clog2(WORDS);
    logic [AW-1:0] idx_q, idx_d;
    logic          busy_q, busy_d;
    logic          we_q, we_d;
    logic [DW-1:0] dat_q, dat_d;
    logic [AW-1:0] widx_q, widx_d;

    // walk the index across all words, one per cycle
    always_comb begin
        idx_d  = idx_q;
        busy_d = busy_q;
        we_d   = 1'b0;
        dat_d  = dat_q;
        widx_d = widx_q;
        if (start_in) begin
            idx_d  = '0;
            busy_d = 1'b1;
        end else if (busy_q) begin
            we_d   = 1'b1;
            dat_d  = nvm_data_in;
            widx_d = idx_q;
            if (idx_q == AW'(WORDS - 1)) begin
                busy_d = 1'b0;
            end else begin
                idx_d = idx_q + AW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            idx_q  <= '0;
            busy_q <= 1'b0;
            we_q   <= 1'b0;
            dat_q  <= '0;
            widx_q <= '0;
        end else begin
            idx_q  <= idx_d;
            busy_q <= busy_d;
            we_q   <= we_d;
            dat_q  <= dat_d;
            widx_q <= widx_d;
        end
    end

    assign nvm_addr_out  = idx_q;
    assign word_data_out = dat_q;
    assign word_idx_out  = widx_q;
    assign word_we_out   = we_q;
    assign busy_out      = busy_q | we_q;
endmodule

/* hw/dhrs_top.sv */
// display hardware reset sequencer: pin filter, blanking, reload, cancel timing
// Contract
// - ignore pulses under 5us, reset above 9us
// - reload settings from storage after release
// - cancel done within 5ms asleep, 120ms awake
// - blank display during reset, then defaults; awake, blanking ends after 120ms even if the pin is still low
// - glitches inside long pulse do not end reset
`timescale 1ns/1ps
`include "dhrs_cfg.svh"
module dhrs_top import dhrs_pkg::*; #(
    parameter int DW         = 8,
    parameter int NVM_WORDS  = `DHRS_NVM_WORDS,
    parameter int CANCEL_SLP = `DHRS_CANCEL_SLP_CYC,
    parameter int CANCEL_AWK = `DHRS_CANCEL_AWK_CYC,
    parameter int BLANK_CYC  = `DHRS_BLANK_CYC
) (
    input  wire logic          sys_clk_in,        // 25 MHz clock
    input  wire logic          sys_rst_in,        // sync reset, high
    input  wire logic          hw_reset_low_pin_in, // reset pin, active low, async
    input  wire logic          sleep_in_in,       // sleep-in state from command core
    input  wire logic          cmd_valid_in,      // host command strobe
    input  wire logic [DW-1:0] cmd_data_in,       // host command byte
    input  wire logic [DW-1:0] nvm_data_in,       // storage read data
    output logic [$clog2(NVM_WORDS)-1:0] nvm_addr_out, // storage word index
    output logic               cmd_valid_out,     // accepted command strobe
    output logic [DW-1:0]      cmd_data_out,      // accepted command byte
    output logic               blank_out,         // display blanked
    output logic               core_rst_out,      // default-state reset to core
    output logic               ready_out,         // reset cancel finished
    output logic [DW*NVM_WORDS-1:0] settings_out  // reloaded id and voltage settings
);
    localparam int AW = $clog2(NVM_WORDS);
    // counters share one width, wide enough for the longer of cancel and blanking
    localparam int CW = $clog2((CANCEL_AWK > BLANK_CYC ? CANCEL_AWK : BLANK_CYC) + 1);
    localparam logic [CW-1:0] REJ = CW'(`DHRS_REJECT_CYC);
    localparam logic [CW-1:0] ACC = CW'(`DHRS_ACCEPT_CYC);
    localparam logic [CW-1:0] GLT = CW'(`DHRS_GLITCH_CYC);

    // two-stage synchroniser for the pin
    logic pin_m_q, pin_s_q;
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pin_m_q <= 1'b1;
            pin_s_q <= 1'b1;
        end else begin
            pin_m_q <= hw_reset_low_pin_in;
            pin_s_q <= pin_m_q;
        end
    end

    dhrs_state_t   st_q, st_d;
    logic [CW-1:0] lo_q, lo_d;      // low width counter
    logic [CW-1:0] hi_q, hi_d;      // high width inside pulse
    logic [CW-1:0] tm_q, tm_d;      // cancel timer
    logic [CW-1:0] lim_q, lim_d;    // cancel limit chosen when the low qualifies as a reset
    logic [CW-1:0] bk_q, bk_d;      // blanking timer
    logic          awake_q, awake_d;
    logic          blank_q, blank_d;
    logic          crst_q, crst_d;
    logic          rdy_q, rdy_d;
    logic          ld_go_q, ld_go_d;
    logic          ld_busy;
    logic          w_we;
    logic [DW-1:0] w_dat;
    logic [AW-1:0] w_idx;

    // reset pulse qualification and cancel sequence
    always_comb begin
        st_d    = st_q;
        lo_d    = lo_q;
        hi_d    = hi_q;
        tm_d    = tm_q;
        lim_d   = lim_q;
        bk_d    = bk_q;
        awake_d = awake_q;
        blank_d = blank_q;
        crst_d  = crst_q;
        rdy_d   = rdy_q;
        ld_go_d = 1'b0;
        // awake blanking runs out after its maximum, even once back in run;
        // asleep it holds; a newly qualified reset below restarts it
        if (blank_q && awake_q) begin
            bk_d = bk_q + CW'(1);
            if (bk_q + CW'(1) >= CW'(BLANK_CYC)) begin
                blank_d = 1'b0;
            end
        end
        case (st_q)
            DHRS_RUN: begin
                if (!pin_s_q) begin
                    if (lo_q != ACC) begin
                        lo_d = lo_q + CW'(1);
                    end
                    // a low longer than the reject width starts a reset
                    if (lo_q >= REJ) begin
                        st_d    = DHRS_LOW;
                        awake_d = ~sleep_in_in;
                        lim_d   = sleep_in_in ? CW'(CANCEL_SLP) : CW'(CANCEL_AWK);
                        blank_d = 1'b1;
                        crst_d  = 1'b1;
                        rdy_d   = 1'b0;
                        bk_d    = '0;
                        hi_d    = '0;
                    end
                end else begin
                    lo_d = '0;
                end
            end
            DHRS_LOW: begin
                if (pin_s_q) begin
                    // short high blips stay inside the pulse
                    hi_d = hi_q + CW'(1);
                    if (hi_q >= GLT) begin
                        st_d    = DHRS_CANCEL;
                        tm_d    = '0;
                        ld_go_d = 1'b1;
                    end
                end else begin
                    hi_d = '0;
                end
            end
            DHRS_CANCEL: begin
                tm_d = tm_q + CW'(1);
                if (tm_q + CW'(1) >= lim_q || (!ld_busy && !ld_go_q && tm_q >= GLT)) begin
                    st_d = DHRS_DONE;
                end
            end
            default: begin
                crst_d = 1'b0;
                rdy_d  = 1'b1;
                lo_d   = '0;
                st_d   = DHRS_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            st_q    <= DHRS_DONE;
            lo_q    <= '0;
            hi_q    <= '0;
            tm_q    <= '0;
            lim_q   <= '0;
            bk_q    <= '0;
            awake_q <= ~`DHRS_SLEEP_RST;
            blank_q <= 1'b1;
            crst_q  <= 1'b1;
            rdy_q   <= 1'b0;
            ld_go_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            lo_q    <= lo_d;
            hi_q    <= hi_d;
            tm_q    <= tm_d;
            lim_q   <= lim_d;
            bk_q    <= bk_d;
            awake_q <= awake_d;
            blank_q <= blank_d;
            crst_q  <= crst_d;
            rdy_q   <= rdy_d;
            ld_go_q <= ld_go_d;
        end
    end

    dhrs_nvm_loader #(
        .WORDS (NVM_WORDS),
        .DW    (DW)
    ) u_loader (
        .sys_clk_in    (sys_clk_in),
        .sys_rst_in    (sys_rst_in),
        .start_in      (ld_go_q),
        .nvm_data_in   (nvm_data_in),
        .nvm_addr_out  (nvm_addr_out),
        .word_data_out (w_dat),
        .word_idx_out  (w_idx),
        .word_we_out   (w_we),
        .busy_out      (ld_busy)
    );

    // settings storage, one word per entry; each entry owns its register
    genvar gi;
    generate
        for (gi = 0; gi < NVM_WORDS; gi++) begin : g_set
            logic [DW-1:0] word_q, word_d;
            always_comb begin
                word_d = word_q;
                if (w_we && w_idx == AW'(gi)) begin
                    word_d = w_dat;
                end
            end
            always_ff @(posedge sys_clk_in) begin
                if (sys_rst_in) begin
                    word_q <= '0;
                end else begin
                    word_q <= word_d;
                end
            end
            assign settings_out[gi*DW +: DW] = word_q;
        end
    endgenerate

    // command gate: drop commands until cancel done
    logic          cv_q, cv_d;
    logic [DW-1:0] cd_q, cd_d;
    always_comb begin
        cv_d = cmd_valid_in && rdy_q && pin_s_q && st_q == DHRS_RUN;
        cd_d = cmd_valid_in ? cmd_data_in : cd_q;
    end
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cv_q <= 1'b0;
            cd_q <= '0;
        end else begin
            cv_q <= cv_d;
            cd_q <= cd_d;
        end
    end

    assign cmd_valid_out = cv_q;
    assign cmd_data_out  = cd_q;
    assign blank_out     = blank_q;
    assign core_rst_out  = crst_q;
    assign ready_out     = rdy_q;

    a_short_reject: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_q == DHRS_RUN && pin_s_q) |=> st_q != DHRS_LOW)
        else $error("reset started without low pin");
    a_cancel_bound: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        st_q == DHRS_CANCEL |-> tm_q < lim_q)
        else $error("cancel overran its limit");
    a_reload_starts: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_q == DHRS_LOW && st_d == DHRS_CANCEL) |=> ##1 ld_busy)
        else $error("reload did not start");
    a_blank_reset: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        st_q == DHRS_LOW |-> blank_q || awake_q)
        else $error("display not blanked");
    a_reset_entry: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_q == DHRS_RUN && st_d == DHRS_LOW) |=> blank_q && crst_q && !rdy_q)
        else $error("reset entry did not blank and hold core");
    a_blank_bound: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (blank_q && awake_q) |-> bk_q < CW'(BLANK_CYC))
        else $error("awake blanking overran its maximum");
    a_glitch_hold: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_q == DHRS_LOW && !pin_s_q) |=> st_q == DHRS_LOW)
        else $error("low pin left reset");
    a_cmd_gate: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_q != DHRS_RUN) |=> !cv_q)
        else $error("command passed during reset");
endmodule

/* include/dhrs_cfg.svh */
// timing constants and reset values for the display hardware reset sequencer
`ifndef DHRS_CFG_SVH
`define DHRS_CFG_SVH
`define DHRS_CLK_MHZ        25
`define DHRS_REJECT_US      5
`define DHRS_ACCEPT_US      9
`define DHRS_PULSE_MIN_US   10
`define DHRS_CANCEL_SLP_MS  5
`define DHRS_CANCEL_AWK_MS  120
`define DHRS_BLANK_MAX_MS   120
`define DHRS_REJECT_CYC     (`DHRS_REJECT_US * `DHRS_CLK_MHZ)
`define DHRS_ACCEPT_CYC     (`DHRS_ACCEPT_US * `DHRS_CLK_MHZ)
`define DHRS_GLITCH_CYC     (`DHRS_REJECT_US * `DHRS_CLK_MHZ)
`define DHRS_CANCEL_SLP_CYC (`DHRS_CANCEL_SLP_MS * 1000 * `DHRS_CLK_MHZ)
`define DHRS_CANCEL_AWK_CYC (`DHRS_CANCEL_AWK_MS * 1000 * `DHRS_CLK_MHZ)
`define DHRS_BLANK_CYC      (`DHRS_BLANK_MAX_MS * 1000 * `DHRS_CLK_MHZ)
`define DHRS_NVM_WORDS      4
`define DHRS_SLEEP_RST      1'b1
`endif

/* include/dhrs_pkg.sv */
// types of the display hardware reset sequencer
package dhrs_pkg;
    typedef enum logic [2:0] {
        DHRS_RUN,
        DHRS_LOW,
        DHRS_CANCEL,
        DHRS_DONE
    } dhrs_state_t;
endpackage

/* sim/dhrs_host_model.sv */
// host model: drives the reset pin and the command strobe
`timescale 1ns/1ps
module dhrs_host_model #(
    parameter int DW          = 8,
    parameter int WAIT_CMD    = 400,
    parameter int WAIT_SLPOUT = 800
) (
    input  wire logic          sys_clk_in, // bench clock
    output logic               pin_out,    // reset pin, active low
    output logic               valid_out,  // command strobe
    output logic [DW-1:0]      data_out    // command byte
);
    int rel_cnt;
    initial begin
        pin_out   = 1'b1;
        valid_out = 1'b0;
        data_out  = '0;
        rel_cnt   = 0;
    end
    // cycles since the pin was last released
    always @(posedge sys_clk_in) rel_cnt <= pin_out ? rel_cnt + 1 : 0;
    // low pulse with an optional short high glitch inside it
    task automatic pulse(input int low, input int gpos, input int glen);
        for (int i = 0; i < low; i++) begin
            // low for the whole pulse, high only inside the glitch window
            @(posedge sys_clk_in) #1 pin_out = (i >= gpos && i < gpos + glen);
        end
        @(posedge sys_clk_in) #1 pin_out = 1'b1;
    endtask
    // one command byte; kind 0 skips the waits, 1 normal, 2 sleep exit
    task automatic send(input logic [DW-1:0] b, input int kind);
        @(posedge sys_clk_in);
        while (kind == 1 && rel_cnt < WAIT_CMD) @(posedge sys_clk_in);
        while (kind == 2 && rel_cnt < WAIT_SLPOUT) @(posedge sys_clk_in);
        #1 valid_out = 1'b1;
        data_out = b;
        @(posedge sys_clk_in) #1 valid_out = 1'b0;
    endtask
endmodule

/* sim/display_hw_reset_sequencer_tb.sv */
// self-checking bench for the display hardware reset sequencer
`timescale 1ns/1ps
module display_hw_reset_sequencer_tb;
    localparam int SLP = 400;
    localparam int AWK = 800;
    localparam int BLK = 600;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic        sleep = 1'b0;
    logic        pin, cmd_v, cmd_v_o, blank, core_rst, ready;
    logic [7:0]  cmd_d, cmd_d_o, b;
    logic [7:0]  nvm_mem [4];
    logic [1:0]  nvm_addr;
    logic [31:0] settings, exp_set;
    logic [7:0]  exp_q [$];
    logic [7:0]  got_q [$];
    bit          drop;
    int          err_total = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          n;

    always #20 clk = ~clk;

    dhrs_host_model #(.WAIT_CMD(SLP), .WAIT_SLPOUT(AWK)) u_host (
        .sys_clk_in(clk), .pin_out(pin), .valid_out(cmd_v), .data_out(cmd_d));
    dhrs_top #(.CANCEL_SLP(SLP), .CANCEL_AWK(AWK), .BLANK_CYC(BLK)) u_dut (
        .sys_clk_in(clk), .sys_rst_in(rst), .hw_reset_low_pin_in(pin), .sleep_in_in(sleep),
        .cmd_valid_in(cmd_v), .cmd_data_in(cmd_d), .nvm_data_in(nvm_mem[nvm_addr]),
        .nvm_addr_out(nvm_addr), .cmd_valid_out(cmd_v_o), .cmd_data_out(cmd_d_o),
        .blank_out(blank), .core_rst_out(core_rst), .ready_out(ready), .settings_out(settings));

    // collect accepted commands and note any drop of ready
    always @(posedge clk) begin
        if (cmd_v_o === 1'b1) got_q.push_back(cmd_d_o);
        if (ready !== 1'b1) drop <= 1'b1;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic final_report;
        if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end

    // new random storage words and the settings they must reload into
    task automatic fill;
        for (int i = 0; i < 4; i++) begin
            nvm_mem[i] = 8'($urandom);
            exp_set[i*8 +: 8] = nvm_mem[i];
        end
    endtask

    // cycles until ready rises (w=0) or blank falls (w=1), bounded by lim
    task automatic wait_for(input bit w, input int lim);
        n = 0;
        while ((w ? blank !== 1'b0 : ready !== 1'b1) && n < lim) begin
            @(posedge clk) #1;
            n++;
        end
    endtask

    // accepted commands against the expected queue
    task automatic chk_cmds;
        chk("cmd_count", exp_q.size(), got_q.size());
        while (exp_q.size() > 0 && got_q.size() > 0) chk("cmd_byte", exp_q.pop_front(), got_q.pop_front());
        exp_q.delete();
        got_q.delete();
    endtask

    // main sequence: spike, awake reset with glitch, asleep reset
    initial begin
        void'($urandom(27));
        fill();
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1 drop = 1'b0;
        u_host.pulse(20 + $urandom % 100, 0, 0);
        repeat (200) @(posedge clk);
        #1;
        chk("spike_no_reset", 0, drop);
        chk("spike_core", 0, core_rst);
        sleep = 1'b0;
        fill();
        fork
            u_host.pulse(250 + $urandom % 100, 140, 30 + $urandom % 60);
            begin
                repeat (160) @(posedge clk);
                u_host.send(8'($urandom), 0);
            end
        join
        chk("rst_core", 1, core_rst);
        chk("rst_blank", 1, blank);
        chk("rst_ready", 0, ready);
        u_host.send(8'($urandom), 0);
        wait_for(0, AWK + 10);
        chk("awake_cancel", 1, n >= 120 && n <= AWK);
        chk("awake_settings", exp_set, settings);
        chk("core_default", 0, core_rst);
        wait_for(1, BLK + AWK);
        chk("awake_blank_end", 1, n <= BLK);
        b = 8'($urandom);
        exp_q.push_back(b);
        u_host.send(b, 1);
        repeat (3) @(posedge clk);
        chk_cmds();
        #1 sleep = 1'b1;
        fill();
        u_host.pulse(140 + $urandom % 85, 0, 0);
        chk("slp_blank", 1, blank);
        wait_for(0, SLP + 10);
        chk("sleep_cancel", 1, n <= SLP);
        chk("sleep_settings", exp_set, settings);
        repeat (BLK + AWK) @(posedge clk);
        #1;
        chk("sleep_stays_blank", 1, blank);
        b = 8'($urandom);
        exp_q.push_back(b);
        u_host.send(b, 2);
        repeat (3) @(posedge clk);
        chk_cmds();
        final_report();
    end
endmodule
